// *** rtl/serial_dac_expander_defs.svh ***
/*
  Field positions, command selectors, mode patterns and reset values of the
  serial converter and expander interface.
  Assumes it is included by its bare name before the package and the module.
*/
`ifndef SERIAL_DAC_EXPANDER_DEFS_SVH
`define SERIAL_DAC_EXPANDER_DEFS_SVH

`define WORD_BITS        16
`define SEL_LSB          0
`define SEL_MSB          3
`define MODE_LSB         4
`define MODE_MSB         7
`define DATA_LSB         8
`define DATA_MSB         15
`define PAR_LSB          4
`define PAR_MSB          15
`define NUM_CHANNELS     12
`define NUM_PINS         12
`define NUM_SHARED       8
`define FIRST_SHARED_CH  5
`define SEL_SPECIAL      4'h0
`define SEL_CH_FIRST     4'h1
`define SEL_CH_LAST      4'hC
`define SEL_EXP_WRITE    4'hD
`define SEL_EXP_SAMPLE   4'hE
`define SEL_DIRECTION    4'hF
`define MODE_CH_CODE     4'h0
`define MODE_CH_EXPANDER 4'h1
`define MODE_ALL_CODE    4'hC
`define MODE_ALL_EXP     4'hD
`define MODE_ALL_RESET   4'hE
`define CODE_RESET       8'h00
`define DIR_RESET        12'h000
`define SR_RESET         16'h0000

`endif

// *** rtl/serial_dac_expander_pkg.sv ***
/*
  Types shared by the serial converter and expander interface.
  Assumes the defs header sits in the include path.
*/
`include "serial_dac_expander_defs.svh"

package serial_dac_expander_pkg;

  typedef logic [7:0]                  code_t;
  typedef logic [`NUM_PINS-1:0]        pins_t;
  typedef logic [`WORD_BITS-1:0]       word_t;

  typedef enum logic [1:0] {
    TGT_SPECIAL,
    TGT_CHANNEL,
    TGT_EXP_WRITE,
    TGT_OTHER
  } target_e;

endpackage : serial_dac_expander_pkg

// *** rtl/serial_dac_expander_interface.sv ***
/*
  Serial command interface and control registers of a twelve channel 8-bit
  converter with a 12-bit parallel expander.
  Assumes clk is much faster than the shift clock, rstn is driven by the
  power-on detector of the interface supply, and the analog side reads the
  code and enable outputs.
*/
`timescale 1ns/1ps
`include "serial_dac_expander_defs.svh"

// Notes on behaviour
// - With chip select low, each rising shift clock edge captures the input bit.
// - A command is one 16-bit word held in a 16-bit shift register.
// - The register's low bit drives serial output, updated on falling shift edges.
// - Serial output is high impedance whenever chip select is high.
// - Chip select falling opens a transfer; host lowers it before clocking.
// - Chip select rising executes the word held in the shift register.
// - Twelve 8-bit code registers, one per converter channel.
// - Twelve expander pins; eight are shared with channels five to twelve.
// - Only serial commands decide input, output or analog use of shared pins.
// - After initialization every expander pin is an undriven input.
// - After initialization the four dedicated outputs show code zero.
// - Power-up of the interface supply initializes everything without host help.
// - Low four bits pick channel, expander write, sample, direction or special.
// - Channel command loads code on mode 0000; mode 0001 returns pin to expander.
// - Expander write copies bits 4 to 15 to pins, driven only where marked output.
// - Direction bit 0 is input, 1 is output; it and codes reset to zero.
module serial_dac_expander_interface
  import serial_dac_expander_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         clk_en,
  input  wire logic                         sclk,
  input  wire logic                         sdi,
  input  wire logic                         cs_n,
  output logic                              sdo,
  output logic                              sdo_oe,
  output logic [8*`NUM_CHANNELS-1:0]        channel_codes,
  output logic [`NUM_SHARED-1:0]            shared_analog_en,
  input  wire logic [`NUM_PINS-1:0]         exp_in,
  output logic [`NUM_PINS-1:0]              exp_out,
  output logic [`NUM_PINS-1:0]              exp_oe
);

  logic [2:0]          sclk_sync_q;
  logic [2:0]          cs_sync_q;
  logic [1:0]          sdi_sync_q;
  pins_t               exp_meta_q;
  pins_t               exp_in_q;
  word_t               sr_q;
  code_t               code_q [`NUM_CHANNELS];
  pins_t               dir_q;
  pins_t               par_out_q;
  logic [`NUM_SHARED-1:0] analog_q;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                cs_fall;
  logic                cs_rise;
  logic                cs_low;
  logic [3:0]          sel;
  logic [3:0]          mode;
  code_t               data;
  pins_t               analog_pins;

  // Maps a shared analog index (channel five is index zero) to its pin number.
  function automatic logic [3:0] shared_pin(input logic [2:0] idx);
    shared_pin = 4'(`NUM_PINS - 1) - {1'b0, idx};
  endfunction : shared_pin

  // Spreads the shared analog enables onto the twelve pin positions.
  function automatic pins_t analog_mask(input logic [`NUM_SHARED-1:0] en);
    pins_t m;
    m = '0;
    for (int i = 0; i < `NUM_SHARED; i++) begin
      m[shared_pin(3'(i))] = en[i];
    end
    analog_mask = m;
  endfunction : analog_mask

  // Edge logic reads stages two and three; stage one is read by stage two alone.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_sync_q <= 3'h0;
      cs_sync_q   <= 3'h7;
      sdi_sync_q  <= 2'h0;
      exp_meta_q  <= '0;
      exp_in_q    <= '0;
    end else if (clk_en) begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      cs_sync_q   <= {cs_sync_q[1:0], cs_n};
      sdi_sync_q  <= {sdi_sync_q[0], sdi};
      exp_meta_q  <= exp_in;
      exp_in_q    <= exp_meta_q;
    end
  end

  assign sclk_rise   = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall   = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign cs_fall     = ~cs_sync_q[1] & cs_sync_q[2];
  assign cs_rise     = cs_sync_q[1] & ~cs_sync_q[2];
  assign cs_low      = ~cs_sync_q[2];
  assign sel         = sr_q[`SEL_MSB:`SEL_LSB];
  assign mode        = sr_q[`MODE_MSB:`MODE_LSB];
  assign data        = sr_q[`DATA_MSB:`DATA_LSB];
  assign analog_pins = analog_mask(analog_q);

  // Shift register: right shift so the first bit sent reaches bit zero after
  // sixteen edges; a sample command reloads the upper twelve bits.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sr_q <= `SR_RESET;
    end else if (clk_en) begin
      if (cs_rise && sel == `SEL_EXP_SAMPLE) begin
        // Pins that drive or carry analog read as zero.
        sr_q[`PAR_MSB:`PAR_LSB] <= exp_in_q & ~dir_q & ~analog_pins;
      end else if (cs_rise && sel == `SEL_SPECIAL && mode == `MODE_ALL_RESET) begin
        sr_q[`DATA_MSB:`DATA_LSB] <= 8'h00;
      end else if (sclk_rise && cs_low && !cs_fall) begin
        sr_q <= {sdi_sync_q[1], sr_q[`WORD_BITS-1:1]};
      end
    end
  end

  // Serial output follows bit zero on falling edges and floats while deselected.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (clk_en) begin
      sdo_oe <= cs_low;
      if (sclk_fall && cs_low) begin
        sdo <= sr_q[0];
      end else if (cs_fall) begin
        sdo <= sr_q[0];
      end
    end
  end

  // Converter code registers.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `NUM_CHANNELS; i++) begin
        code_q[i] <= `CODE_RESET;
      end
    end else if (clk_en && cs_rise) begin
      if (sel >= `SEL_CH_FIRST && sel <= `SEL_CH_LAST && mode == `MODE_CH_CODE) begin
        code_q[sel - 4'h1] <= data;
      end else if (sel == `SEL_SPECIAL && mode == `MODE_ALL_CODE) begin
        for (int i = 0; i < `NUM_CHANNELS; i++) begin
          code_q[i] <= data;
        end
      end else if (sel == `SEL_SPECIAL && mode == `MODE_ALL_RESET) begin
        for (int i = 0; i < `NUM_CHANNELS; i++) begin
          code_q[i] <= `CODE_RESET;
        end
      end
    end
  end

  // Analog use of the shared pins; a code write turns analog on, the expander
  // pattern turns it off, so nothing but commands changes the pin role.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      analog_q <= '0;
    end else if (clk_en && cs_rise) begin
      if (sel >= 4'(`FIRST_SHARED_CH) && sel <= `SEL_CH_LAST) begin
        if (mode == `MODE_CH_CODE) begin
          analog_q[3'(sel - 4'(`FIRST_SHARED_CH))] <= 1'b1;
        end else if (mode == `MODE_CH_EXPANDER) begin
          analog_q[3'(sel - 4'(`FIRST_SHARED_CH))] <= 1'b0;
        end
      end else if (sel == `SEL_SPECIAL) begin
        if (mode == `MODE_ALL_CODE) begin
          analog_q <= '1;
        end else if (mode == `MODE_ALL_EXP || mode == `MODE_ALL_RESET) begin
          analog_q <= '0;
        end
      end
    end
  end

  // Direction register and parallel output latch.
  // The latch keeps its value across direction changes, so a pin that is made
  // an output again shows the last level written to it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_q     <= `DIR_RESET;
      par_out_q <= '0;
    end else if (clk_en && cs_rise) begin
      if (sel == `SEL_DIRECTION) begin
        dir_q <= sr_q[`PAR_MSB:`PAR_LSB];
      end else if (sel == `SEL_EXP_WRITE) begin
        par_out_q <= sr_q[`PAR_MSB:`PAR_LSB];
      end else if (sel == `SEL_SPECIAL && mode == `MODE_ALL_RESET) begin
        dir_q <= `DIR_RESET;
      end
    end
  end

  // Registered pin controls; direction wins over analog use on a shared pin.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exp_out          <= '0;
      exp_oe           <= '0;
      shared_analog_en <= '0;
      channel_codes    <= '0;
    end else if (clk_en) begin
      exp_out <= par_out_q & dir_q;
      exp_oe  <= dir_q;
      for (int i = 0; i < `NUM_SHARED; i++) begin
        shared_analog_en[i] <= analog_q[i] & ~dir_q[shared_pin(3'(i))];
      end
      for (int i = 0; i < `NUM_CHANNELS; i++) begin
        channel_codes[8*i +: 8] <= code_q[i];
      end
    end
  end

endmodule : serial_dac_expander_interface

// *** bench/serial_dac_expander_props.sv ***
/* Port checker for the serial converter and expander interface.
   Assumes clk_en stays high and the host idles sclk low between frames. */
`timescale 1ns/1ps
module serial_dac_expander_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire logic        sclk,
  input wire logic        sdi,
  input wire logic        cs_n,
  input wire logic        sdo,
  input wire logic        sdo_oe,
  input wire logic [95:0] channel_codes,
  input wire logic [7:0]  shared_analog_en,
  input wire logic [11:0] exp_in,
  input wire logic [11:0] exp_out,
  input wire logic [11:0] exp_oe
);
  logic [7:0] dir_rev;
  // Analog enable bit i belongs to pin 11-i, so the direction bits are reversed.
  assign dir_rev = {exp_oe[4], exp_oe[5], exp_oe[6], exp_oe[7],
                    exp_oe[8], exp_oe[9], exp_oe[10], exp_oe[11]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_oe_idle_off: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("sdo on when idle");
  a_oe_sel_on: assert property (!cs_n [*6] |-> sdo_oe)
    else $error("sdo off when selected");
  a_out_masked: assert property ((exp_out & ~exp_oe) == 12'h000)
    else $error("input pin driven");
  a_dir_wins: assert property ((shared_analog_en & dir_rev) == 8'h00)
    else $error("analog on output pin");
  a_reset_clear: assert property ($rose(rstn) |-> channel_codes == 96'h0
    && exp_oe == 12'h000 && shared_analog_en == 8'h00 && !sdo_oe)
    else $error("state not cleared");
  a_idle_hold: assert property (cs_n [*8] |=> $stable({channel_codes, exp_oe, exp_out}))
    else $error("change while idle");
  a_exec_on_rise: assert property ($past(rstn)
    && $changed({channel_codes, exp_oe, shared_analog_en})
    |-> cs_n && $past(cs_n, 3))
    else $error("change before cs rise");
  a_sdo_steady: assert property ((!cs_n && sclk) [*5] |=> $stable(sdo))
    else $error("sdo moved on high sclk");
endmodule : serial_dac_expander_props
bind serial_dac_expander_interface serial_dac_expander_props u_chk (.clk(clk), .rstn(rstn),
  .clk_en(clk_en), .sclk(sclk), .sdi(sdi), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe),
  .channel_codes(channel_codes), .shared_analog_en(shared_analog_en), .exp_in(exp_in),
  .exp_out(exp_out), .exp_oe(exp_oe));

// *** bench/serial_host_model.sv ***
/* Host model that frames 16-bit words on the serial pins.
   Assumes clk is the 8 ns bench clock and sdo_pin floats when undriven. */
`timescale 1ns/1ps
module serial_host_model
  import serial_dac_expander_pkg::*;
(
  input  wire logic clk,
  output logic      sclk,
  output logic      sdi,
  output logic      cs_n,
  input  wire logic sdo_pin
);
  initial begin
    sclk = 1'b0;
    sdi  = 1'b0;
    cs_n = 1'b1;
  end
  // Ten clocks per half period gives a 160 ns shift period, faster than a real
  // host may run; the logic only needs each half period to exceed four clocks.
  task automatic xfer(input word_t w, output word_t r);
    @(posedge clk) cs_n <= 1'b0;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      r[i] = sdo_pin;
      sdi <= w[i];
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      repeat (10) @(posedge clk);
      sclk <= 1'b0;
      repeat (5) @(posedge clk);
    end
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (12) @(posedge clk);
  endtask : xfer
endmodule : serial_host_model

// *** bench/serial_dac_expander_interface_tb_top.sv ***
/* Self-checking bench: a host model sends words, a model here predicts results.
   Assumes the package, the host model and the checker are compiled first. */
`timescale 1ns/1ps
module serial_dac_expander_interface_tb_top
  import serial_dac_expander_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, sclk, sdi, cs_n, sdo, sdo_oe;
  logic [95:0] codes;
  logic [7:0]  an_en;
  pins_t       exp_in = 12'h000, exp_out, exp_oe;
  wire         sdo_pin;
  word_t       sr = 16'h0000, rd;
  int          error_cnt, cmp_count, cyc, dir, latch, an, code [12], seed = 11773;

  always #4 clk = ~clk;
  assign sdo_pin = sdo_oe ? sdo : 1'bz;
  serial_dac_expander_interface dut (.clk(clk), .rstn(rstn), .clk_en(1'b1), .sclk(sclk),
    .sdi(sdi), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .channel_codes(codes),
    .shared_analog_en(an_en), .exp_in(exp_in), .exp_out(exp_out), .exp_oe(exp_oe));
  serial_host_model host (.clk(clk), .sclk(sclk), .sdi(sdi), .cs_n(cs_n), .sdo_pin(sdo_pin));

  task automatic chk(string n, logic [95:0] e, logic [95:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic check_state();
    logic [95:0] c;
    logic [7:0]  dr;
    foreach (code[k]) c[8*k +: 8] = code[k][7:0];
    for (int i = 0; i < 8; i++) dr[i] = dir[11-i];
    chk("codes", c, codes);
    chk("exp_oe", 96'(dir[11:0]), 96'(exp_oe));
    chk("exp_out", 96'(latch[11:0] & dir[11:0]), 96'(exp_out));
    chk("analog", 96'(an[7:0] & ~dr), 96'(an_en));
  endtask : check_state

  task automatic send(input word_t w);
    int    s, m, d;
    pins_t pa;
    s = w[3:0];
    m = w[7:4];
    d = w[15:8];
    foreach (pa[p]) pa[p] = (p >= 4) && an[11-p];
    host.xfer(w, rd);
    chk("sdo", 96'(sr), 96'(rd));
    sr = w;
    if (s >= 1 && s <= 12 && m == 0) code[s-1] = d;
    if (s >= 5 && s <= 12 && m < 2) an[s-5] = (m == 0);
    if (s == 13) latch = w[15:4];
    if (s == 14) sr[15:4] = exp_in & ~dir[11:0] & ~pa;
    if (s == 15) dir = w[15:4];
    if (s == 0 && m >= 12 && m <= 14) begin
      foreach (code[k]) code[k] = (m == 12) ? d : (m == 13) ? code[k] : 0;
      an = (m == 12) ? 8'hFF : 8'h00;
    end
    if (s == 0 && m == 14) begin
      dir = 0;
      sr[15:8] = 8'h00;
    end
    check_state();
  endtask : send

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    check_state();
    for (int k = 1; k <= 12; k++) send({8'($random(seed)), 4'h0, 4'(k)});
    for (int k = 5; k <= 12; k += 3) send({8'h00, 4'h1, 4'(k)});
    send({12'h0F3, 4'hF});
    send({12'hA5C, 4'hD});
    exp_in <= 12'($random(seed));
    send(16'h000E);
    send(16'h5AC0);
    send(16'h00D0);
    send(16'hFFB0);
    send(16'h3373);
    send(16'hFFE0);
    for (int n = 0; n < 24; n++) begin
      exp_in <= 12'($random(seed));
      send(16'($random(seed)));
    end
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (code[k]) code[k] = 0;
    {dir, latch, an, sr} = '0;
    repeat (5) @(posedge clk);
    send({12'hFFF, 4'hF});
    conclude();
  end
endmodule : serial_dac_expander_interface_tb_top
